// ===== gpb_bank_top.sv
// seven-port gpio bank with a wishbone classic register slave
// assumes the pad ring outside turns o/oe/pullup into real pins
`timescale 1ns/1ns
module gpb_bank_top
  import gpb_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [gpb_pkg::WB_ADR_W-1:0] i_wb_adr,
  input wire logic [gpb_pkg::WB_SEL_W-1:0] i_wb_sel,
  input wire logic [gpb_pkg::WB_DAT_W-1:0] i_wb_dat,
  output logic [gpb_pkg::WB_DAT_W-1:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic [gpb_pkg::NUM_PINS-1:0] i_pad_i,
  output logic [gpb_pkg::NUM_PINS-1:0] o_pad_o,
  output logic [gpb_pkg::NUM_PINS-1:0] o_pad_oe,
  output logic [gpb_pkg::NUM_PINS-1:0] o_pad_pu
);

  // ==========================================================
  // bus decode
  logic ack_d, ack_q;
  logic req;
  logic wr;
  logic mod_sel;
  logic [IDX_W-1:0] idx;
  logic [NUM_PORTS-1:0] hit_out, hit_lvl, hit_dir;
  // unpacked so that each port's flops belong to their own process
  logic [PORT_W-1:0] out_q [NUM_PORTS];
  logic [PORT_W-1:0] dir_q [NUM_PORTS];
  logic [PORT_W-1:0] lvl [NUM_PORTS];

  // one access per ack; the ack_q term stops a double write
  assign req = i_wb_cyc & i_wb_stb & ~ack_q;
  assign wr = req & i_wb_we & i_wb_sel[0];
  assign mod_sel = i_wb_adr[MOD_BIT];
  assign idx = i_wb_adr[IDX_MSB:IDX_LSB];

  always_comb begin
    ack_d = req;
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end

  assign o_wb_ack = ack_q;

  // ==========================================================
  // per-port registers and pads
  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_port
      logic [PORT_W-1:0] out_d, dir_d;

      assign hit_out[p] = (mod_sel == PORT_MOD[p]) && (idx == OUT_IDX[p]);
      assign hit_lvl[p] = (mod_sel == PORT_MOD[p]) && (idx == LVL_IDX[p]);
      assign hit_dir[p] = (mod_sel == PORT_MOD[p]) && (idx == DIR_IDX[p]);

      always_comb begin
        out_d = out_q[p];
        dir_d = dir_q[p];
        // latch changes only on its own address, never on a direction write
        if (wr && hit_out[p]) begin
          out_d = i_wb_dat[PORT_W-1:0];
        end
        if (wr && hit_dir[p]) begin
          dir_d = i_wb_dat[PORT_W-1:0] & DIR_MASK[p];
        end
      end

      always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
          out_q[p] <= OUT_RST;
          dir_q[p] <= DIR_RST;
        end else begin
          out_q[p] <= out_d;
          dir_q[p] <= dir_d;
        end
      end

      gpb_pad_cell u_pad (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_out_bits(out_q[p]),
        .i_dir_bits(dir_q[p]),
        .i_pad_i(i_pad_i[p*PORT_W +: PORT_W]),
        .o_pad_o(o_pad_o[p*PORT_W +: PORT_W]),
        .o_pad_oe(o_pad_oe[p*PORT_W +: PORT_W]),
        .o_pad_pu(o_pad_pu[p*PORT_W +: PORT_W]),
        .o_level(lvl[p])
      );
    end
  endgenerate

  // ==========================================================
  // read data
  // unmapped addresses still ack and read as zero
  logic [WB_DAT_W-1:0] rdat_d, rdat_q;

  always_comb begin
    rdat_d = rdat_q;
    if (req && !i_wb_we) begin
      rdat_d = '0;
      for (int k = 0; k < NUM_PORTS; k++) begin
        if (hit_out[k]) begin
          rdat_d[PORT_W-1:0] = out_q[k];
        end
        if (hit_lvl[k]) begin
          rdat_d[PORT_W-1:0] = lvl[k];
        end
        if (hit_dir[k]) begin
          rdat_d[PORT_W-1:0] = dir_q[k];
        end
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rdat_q <= RDAT_RST;
    end else begin
      rdat_q <= rdat_d;
    end
  end

  assign o_wb_dat = rdat_q;

endmodule // gpb_bank_top

// ===== gpb_pkg.sv
// constants for the seven-port gpio register bank
// assumes a wishbone classic slave with 32-bit data and byte addresses
package gpb_pkg;

  // ==========================================================
  // sizes
  localparam int NUM_PORTS = 7;
  localparam int PORT_W = 8;
  localparam int NUM_PINS = NUM_PORTS * PORT_W;
  localparam int WB_ADR_W = 8;
  localparam int WB_DAT_W = 32;
  localparam int WB_SEL_W = 4;
  localparam int IDX_W = 5;

  // ==========================================================
  // address map: word index = module * 32 + register index
  localparam int WORD_LSB = 2;
  localparam int MOD_BIT = 7;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 6;
  // module select per port, bit p for port p
  localparam logic [NUM_PORTS-1:0] PORT_MOD = 7'h70;
  // register indices per port, entry p for port p
  localparam logic [NUM_PORTS-1:0][IDX_W-1:0] OUT_IDX =
    {5'h02, 5'h01, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00};
  localparam logic [NUM_PORTS-1:0][IDX_W-1:0] LVL_IDX =
    {5'h0a, 5'h09, 5'h08, 5'h0b, 5'h0a, 5'h09, 5'h08};
  localparam logic [NUM_PORTS-1:0][IDX_W-1:0] DIR_IDX =
    {5'h12, 5'h11, 5'h10, 5'h13, 5'h12, 5'h11, 5'h10};

  // ==========================================================
  // field layout and reset values
  localparam logic [NUM_PORTS-1:0][PORT_W-1:0] DIR_MASK =
    {8'hff, 8'hff, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hff};
  localparam logic [PORT_W-1:0] OUT_RST = 8'h00;
  localparam logic [PORT_W-1:0] DIR_RST = 8'h00;
  localparam logic [WB_DAT_W-1:0] RDAT_RST = 32'h0000_0000;

endpackage

// ===== gpb_pad_cell.sv
// pad control and input synchroniser for one 8-bit port
// assumes the pad ring resolves o/oe/pullup into the wire level
`timescale 1ns/1ns
module gpb_pad_cell
  import gpb_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [gpb_pkg::PORT_W-1:0] i_out_bits,
  input wire logic [gpb_pkg::PORT_W-1:0] i_dir_bits,
  input wire logic [gpb_pkg::PORT_W-1:0] i_pad_i,
  output logic [gpb_pkg::PORT_W-1:0] o_pad_o,
  output logic [gpb_pkg::PORT_W-1:0] o_pad_oe,
  output logic [gpb_pkg::PORT_W-1:0] o_pad_pu,
  output logic [gpb_pkg::PORT_W-1:0] o_level
);

  // ==========================================================
  // drive state
  logic [PORT_W-1:0] o_d, o_q, oe_d, oe_q, pu_d, pu_q;

  always_comb begin
    o_d = i_out_bits;
    oe_d = i_dir_bits;
    pu_d = ~i_dir_bits & i_out_bits;
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_q <= OUT_RST;
      oe_q <= DIR_RST;
      pu_q <= OUT_RST;
    end else begin
      o_q <= o_d;
      oe_q <= oe_d;
      pu_q <= pu_d;
    end
  end

  assign o_pad_o = o_q;
  assign o_pad_oe = oe_q;
  assign o_pad_pu = pu_q;

  // ==========================================================
  // input synchroniser
  // first stage feeds only the second; pins are asynchronous to us
  logic [PORT_W-1:0] s1_d, s1_q, s2_d, s2_q;

  always_comb begin
    s1_d = i_pad_i;
    s2_d = s1_q;
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end

  assign o_level = s2_q;

endmodule // gpb_pad_cell

// ===== gpb_bank_asserts.sv
// assertions on the gpio bank ports
// bound to gpb_bank_top from tb
`timescale 1ns/1ns
module gpb_chk (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic [55:0] o_pad_o,
  input wire logic [55:0] o_pad_oe,
  input wire logic [55:0] o_pad_pu
);
  logic rq, w0, wd;
  assign rq = i_wb_cyc && i_wb_stb && !o_wb_ack;
  // a write with byte lane 0 off stores nothing
  assign w0 = rq && i_wb_we && i_wb_sel[0] && i_wb_adr == 8'h00;
  assign wd = rq && i_wb_we && i_wb_sel[0] && i_wb_adr == 8'h40;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  property p_ack; rq |=> o_wb_ack; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_one; o_wb_ack |=> !o_wb_ack; endproperty
  a_one: assert property (p_one) else $error("ack long");
  property p_hi; o_wb_ack |-> o_wb_dat[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("data high");
  property p_pu; o_pad_pu == (o_pad_o & ~o_pad_oe); endproperty
  a_pu: assert property (p_pu) else $error("pullup");
  property p_p4; o_pad_oe[39:38] == 2'b00; endproperty
  a_p4: assert property (p_p4) else $error("p4 drive");
  property p_out; w0 |-> ##2 o_pad_o[7:0] == $past(i_wb_dat[7:0], 2); endproperty
  a_out: assert property (p_out) else $error("level");
  property p_dir; wd |-> ##2 o_pad_oe[7:0] == $past(i_wb_dat[7:0], 2); endproperty
  a_dir: assert property (p_dir) else $error("direction");
  property p_keep; wd |-> ##2 $stable(o_pad_o[7:0]); endproperty
  a_keep: assert property (p_keep) else $error("latch lost");
endmodule // gpb_chk

// ===== gpb_pins.sv
// far-side pin model
// undriven pins without pullup or external drive (i_en low) flicker, never a steady level
`timescale 1ns/1ns
module gpb_pins (
  input wire logic i_clk,
  input wire logic [55:0] i_o,
  input wire logic [55:0] i_oe,
  input wire logic [55:0] i_pu,
  input wire logic [55:0] i_ext,
  input wire logic [55:0] i_en,
  output logic [55:0] o_lvl
);
  logic tog_q = 1'b0;
  always @(posedge i_clk) tog_q <= ~tog_q;
  assign o_lvl = i_oe & i_o | ~i_oe & (i_en & i_ext | ~i_en & (i_pu | {56{tog_q}}));
endmodule // gpb_pins

// ===== tb.sv
// bench for gpb_bank_top
// uses gpb_pins and gpb_chk
`timescale 1ns/1ns
module tb;
  import gpb_pkg::*;
  logic i_mclk = 1'b0, i_rst = 1'b1, cyc = 1'b0, we = 1'b0, ack;
  logic [7:0] adr = 8'h00, wd = 8'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] rdat;
  logic [55:0] ext = 56'h0, en = 56'h0, lvl, po, poe, ppu;
  int num_errors = 0, checks = 0;
  always #2 i_mclk = ~i_mclk;
  gpb_bank_top i_gpb_bank_top (.i_mclk, .i_rst, .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat({24'h0, wd}), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_pad_i(lvl), .o_pad_o(po), .o_pad_oe(poe), .o_pad_pu(ppu));
  gpb_pins i_gpb_pins (.i_clk(i_mclk), .i_o(po), .i_oe(poe), .i_pu(ppu), .i_ext(ext), .i_en(en),
    .o_lvl(lvl));
  task automatic final_report;
    $display("%0d errors, %0d checks", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %0t: %h not %h", $time, g, e);
    end
  endtask
  // a read compares with d
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge i_mclk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    for (n = 0; n < 9 && ack !== 1'b1; n++) @(posedge i_mclk);
    cyc <= 1'b0;
    chk(8'(n == 9), 8'h00);
    if (n == 9) final_report();
    else if (!w) chk(rdat[7:0], d);
  endtask
  task automatic t_ports;
    for (int p = 0; p < 7; p++) begin
      logic [7:0] o, d, v;
      o = {PORT_MOD[p], OUT_IDX[p], 2'b00};
      d = {PORT_MOD[p], DIR_IDX[p], 2'b00};
      v = 8'h5a ^ 8'(p);
      wb(1'b1, o, v);
      wb(1'b1, d, 8'hff);
      wb(1'b0, d, p == 4 ? 8'h3f : 8'hff);
      chk(po[p*8+:8], v);
      chk(poe[p*8+:8], p == 4 ? 8'h3f : 8'hff);
      wb(1'b1, d, 8'h00);
      wb(1'b0, o, v);
      chk(ppu[p*8+:8], v);
    end
  endtask
  task automatic t_pins;
    wb(1'b1, 8'h04, 8'hff);
    // byte lane 0 off: the write is acked but stores nothing
    sel <= 4'he;
    wb(1'b1, 8'h04, 8'h00);
    sel <= 4'hf;
    wb(1'b0, 8'h04, 8'hff);
    ext[15:8] <= 8'h0a;
    en[15:8] <= 8'h0f;
    wb(1'b1, 8'h24, 8'h00);
    wb(1'b0, 8'h24, 8'hfa);
    // a read taken two edges after a pin change still sees the old level
    ext[15:8] <= 8'h05;
    wb(1'b0, 8'h24, 8'hfa);
    wb(1'b0, 8'h24, 8'hf5);
    wb(1'b0, 8'hfc, 8'h00);
  endtask
  // reset in mid-run: pads float, latch and direction return to reset values
  task automatic t_reset;
    @(posedge i_mclk);
    i_rst <= 1'b1;
    repeat (8) @(posedge i_mclk);
    chk(8'(|{po, poe, ppu, rdat, ack}), 8'h00);
    i_rst <= 1'b0;
    wb(1'b0, 8'h04, OUT_RST);
    wb(1'b0, 8'h44, DIR_RST);
  endtask
  initial begin
    repeat (8) @(posedge i_mclk);
    i_rst <= 1'b0;
    t_ports();
    t_pins();
    t_reset();
    final_report();
  end
endmodule // tb
bind gpb_bank_top gpb_chk i_gpb_chk (.*);
